// >>> design/ldmc_pkg.sv
// package for the lane data path mute control register block
// assumes an ahb-lite master with 32-bit word accesses only
package ldmc_pkg;
    localparam int LANES = 8;
    // advertisement page and bit positions
    localparam logic [7:0] OFS_LAYOUT_ADV = 8'h02;
    localparam int BIT_LAYOUT_PAGE = 7;
    localparam logic [7:0] OFS_SIGNAL_ADV = 8'h8E;
    localparam int BIT_SIGNAL_PAGE = 3;
    // lane control page byte offsets (byte addresses, banked by 8 lanes)
    localparam logic [7:0] OFS_TEARDOWN = 8'h80;
    localparam logic [7:0] OFS_DIRECT_FIRST = 8'h81;
    localparam logic [7:0] OFS_DIRECT_LAST = 8'h8E;
    localparam logic [7:0] OFS_SET0_FIRST = 8'h8F;
    localparam logic [7:0] OFS_SET1_LAST = 8'hD4;
    localparam logic [7:0] OFS_MASK_FIRST = 8'hD5;
    localparam logic [7:0] OFS_MASK_LAST = 8'hE8;
    // register indices; each word sits at four times its index
    localparam logic [7:0] IDX_TEARDOWN = 8'h80;
    localparam logic [7:0] IDX_TX_OFF = 8'h81;
    localparam logic [7:0] IDX_TX_FORCE_SQ = 8'h82;
    localparam logic [7:0] IDX_TX_AUTO_SQ_OFF = 8'h83;
    localparam logic [7:0] IDX_RX_OFF = 8'h84;
    localparam logic [7:0] IDX_RX_AUTO_SQ_OFF = 8'h85;
    localparam logic [7:0] IDX_STATUS = 8'h86;
    localparam logic [7:0] IDX_ADVERT = 8'h87;
    localparam logic [7:0] IDX_BANK = 8'h88;
    localparam logic [11:0] ADR_TEARDOWN = {2'b00, IDX_TEARDOWN, 2'b00};
    localparam logic [11:0] ADR_TX_OFF = {2'b00, IDX_TX_OFF, 2'b00};
    localparam logic [11:0] ADR_TX_FORCE_SQ = {2'b00, IDX_TX_FORCE_SQ, 2'b00};
    localparam logic [11:0] ADR_TX_AUTO_SQ_OFF = {2'b00, IDX_TX_AUTO_SQ_OFF, 2'b00};
    localparam logic [11:0] ADR_RX_OFF = {2'b00, IDX_RX_OFF, 2'b00};
    localparam logic [11:0] ADR_RX_AUTO_SQ_OFF = {2'b00, IDX_RX_AUTO_SQ_OFF, 2'b00};
    localparam logic [11:0] ADR_STATUS = {2'b00, IDX_STATUS, 2'b00};
    localparam logic [11:0] ADR_ADVERT = {2'b00, IDX_ADVERT, 2'b00};
    localparam logic [11:0] ADR_BANK = {2'b00, IDX_BANK, 2'b00};
    localparam logic [7:0] RST_TEARDOWN = 8'h00;
    localparam logic [7:0] RST_LANE = 8'h00;
    localparam logic [1:0] BANK_LAST = 2'h3;
    localparam logic [1:0] RST_BANK = 2'h0;
    typedef enum logic [3:0] {
        LDMC_DP_OFF = 4'h1,
        LDMC_DP_INIT = 4'h2,
        LDMC_DP_ACT = 4'h4,
        LDMC_DP_DOWN = 4'h8
    } ldmc_dp_type;
endpackage

// >>> design/ldmc_top.sv
// lane data path mute control: ahb-lite register slave, per-lane data path
// state machines and the tx/rx muting combination
// assumes hclk domain status inputs and that a lane's data path engine
// reports ready/done; external pins pass a two-flop synchroniser
`timescale 1ns/100ps
// Notes on behaviour
// - advertise lane control page in layout flag
// - advertise optional signal page by own bit
// - each bank controls exactly eight lanes
// - teardown byte 128, direct 129-142, masks 213-232
// - two staged sets at 143-177 and 178-212
// - teardown byte acted on only when operational
// - clear bit initializes, set bit tears down
// - all paths auto-initialize when bits clear
// - every data path runs independently
// - teardown bits are levels, continuously honored
// - direct controls act immediately, unstaged
// - tx stays muted while path initializing
// - disable masks squelch on tx output
// - state machine may hold tx disabled
// - tx squelch by force or auto controller
// - host may turn off tx auto squelch
// - non-pluggable-host category lacks tx auto squelch
// - rx disable host only, output quiescent
// - no host command forces rx squelch
// - rx squelched until inputs valid and ready
// - host may turn off rx auto squelch
module ldmc_top #(
    parameter bit TX_AUTO_SQ_SUPPORTED = 1'b1,
    parameter bit RX_AUTO_SQ_SUPPORTED = 1'b1,
    parameter bit SIGNAL_PAGE_SUPPORTED = 1'b0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic module_operational_state,
    input wire logic module_low_power_state,
    input wire logic non_pluggable_host_category,
    input wire logic [7:0] dp_init_done,
    input wire logic [7:0] dp_deinit_done,
    input wire logic [7:0] tx_input_valid,
    input wire logic [7:0] rx_input_valid,
    input wire logic [7:0] rx_resources_ready,
    output logic [7:0] tx_output_disabled,
    output logic [7:0] tx_output_squelched,
    output logic [7:0] rx_output_disabled,
    output logic [7:0] rx_output_squelched,
    output logic [1:0] lane_bank
);
    localparam int L = ldmc_pkg::LANES;

    logic [7:0] data_path_teardown_request;
    logic [7:0] tx_output_off_control;
    logic [7:0] tx_force_squelch;
    logic [7:0] tx_auto_squelch_off;
    logic [7:0] rx_output_off_control;
    logic [7:0] rx_auto_squelch_off;
    logic [1:0] bank;
    logic ap_valid;
    logic ap_write;
    logic [11:0] ap_addr;
    logic [7:0] tx_valid_s1, tx_valid_s2, rx_valid_s1, rx_valid_s2;
    logic oper_s1, oper_s2;
    logic low_pwr_s1, low_pwr_s2;
    logic host_cat_s1, host_cat_s2;
    logic wr_hit;
    logic [7:0] tx_auto_sq, rx_ready;
    logic [7:0] next_tx_disabled, next_tx_squelched;
    logic [7:0] next_rx_disabled, next_rx_squelched;
    ldmc_pkg::ldmc_dp_type data_path_state_machine [L];
    logic [7:0] dp_initializing, dp_active;
    logic [31:0] next_rdata;

    // pins from the optics domain pass two flops first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_valid_s1 <= 8'h00;
            tx_valid_s2 <= 8'h00;
            rx_valid_s1 <= 8'h00;
            rx_valid_s2 <= 8'h00;
            oper_s1 <= 1'b0;
            oper_s2 <= 1'b0;
            low_pwr_s1 <= 1'b1;
            low_pwr_s2 <= 1'b1;
            host_cat_s1 <= 1'b0;
            host_cat_s2 <= 1'b0;
        end else begin
            tx_valid_s1 <= tx_input_valid;
            tx_valid_s2 <= tx_valid_s1;
            rx_valid_s1 <= rx_input_valid;
            rx_valid_s2 <= rx_valid_s1;
            oper_s1 <= module_operational_state;
            oper_s2 <= oper_s1;
            low_pwr_s1 <= module_low_power_state;
            low_pwr_s2 <= low_pwr_s1;
            host_cat_s1 <= non_pluggable_host_category;
            host_cat_s2 <= host_cat_s1;
        end
    end

    // ahb address phase capture; slave answers with zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 12'h000;
        end else if (hready) begin
            ap_valid <= hsel && htrans[1];
            ap_write <= hwrite;
            ap_addr <= {haddr[11:2], 2'b00};
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // writes land in the data phase; direct controls act next cycle
    // staged sets and masks are not held here; they read as zero
    assign wr_hit = ap_valid && ap_write;

    // teardown byte at the first word of the page
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_path_teardown_request <= ldmc_pkg::RST_TEARDOWN;
        end else if (wr_hit && ap_addr == ldmc_pkg::ADR_TEARDOWN) begin
            data_path_teardown_request <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_output_off_control <= ldmc_pkg::RST_LANE;
        end else if (wr_hit && ap_addr == ldmc_pkg::ADR_TX_OFF) begin
            tx_output_off_control <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_force_squelch <= ldmc_pkg::RST_LANE;
        end else if (wr_hit && ap_addr == ldmc_pkg::ADR_TX_FORCE_SQ) begin
            tx_force_squelch <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_auto_squelch_off <= ldmc_pkg::RST_LANE;
        end else if (wr_hit && ap_addr == ldmc_pkg::ADR_TX_AUTO_SQ_OFF) begin
            tx_auto_squelch_off <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_output_off_control <= ldmc_pkg::RST_LANE;
        end else if (wr_hit && ap_addr == ldmc_pkg::ADR_RX_OFF) begin
            rx_output_off_control <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_auto_squelch_off <= ldmc_pkg::RST_LANE;
        end else if (wr_hit && ap_addr == ldmc_pkg::ADR_RX_AUTO_SQ_OFF) begin
            rx_auto_squelch_off <= hwdata[7:0];
        end
    end

    // only two bits kept; higher bank numbers wrap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bank <= ldmc_pkg::RST_BANK;
        end else if (wr_hit && ap_addr == ldmc_pkg::ADR_BANK) begin
            bank <= hwdata[1:0];
        end
    end

    // each bank selects a group of eight lanes
    assign lane_bank = bank;

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (ap_addr)
            ldmc_pkg::ADR_TEARDOWN: next_rdata[7:0] = data_path_teardown_request;
            ldmc_pkg::ADR_TX_OFF: next_rdata[7:0] = tx_output_off_control;
            ldmc_pkg::ADR_TX_FORCE_SQ: next_rdata[7:0] = tx_force_squelch;
            ldmc_pkg::ADR_TX_AUTO_SQ_OFF: next_rdata[7:0] = tx_auto_squelch_off;
            ldmc_pkg::ADR_RX_OFF: next_rdata[7:0] = rx_output_off_control;
            ldmc_pkg::ADR_RX_AUTO_SQ_OFF: next_rdata[7:0] = rx_auto_squelch_off;
            ldmc_pkg::ADR_STATUS: next_rdata[15:0] = {dp_active, dp_initializing};
            ldmc_pkg::ADR_ADVERT: begin
                next_rdata[ldmc_pkg::BIT_LAYOUT_PAGE] = 1'b1;
                next_rdata[8 + ldmc_pkg::BIT_SIGNAL_PAGE] = SIGNAL_PAGE_SUPPORTED;
            end
            ldmc_pkg::ADR_BANK: next_rdata[1:0] = bank;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // read data comes straight from the held address in the data phase
    assign hrdata = (ap_valid && !ap_write) ? next_rdata : 32'h0000_0000;

    // one state machine per lane; lanes never wait on each other
    for (genvar i = 0; i < L; i++) begin : g_dp
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                data_path_state_machine[i] <= ldmc_pkg::LDMC_DP_OFF;
            end else begin
                case (data_path_state_machine[i])
                    ldmc_pkg::LDMC_DP_OFF: begin
                        // level request, read only when operational
                        // low power keeps paths off so the host can set bits
                        if (oper_s2 && !low_pwr_s2 && !data_path_teardown_request[i]) begin
                            data_path_state_machine[i] <= ldmc_pkg::LDMC_DP_INIT;
                        end
                    end
                    ldmc_pkg::LDMC_DP_INIT: begin
                        if (oper_s2 && data_path_teardown_request[i]) begin
                            data_path_state_machine[i] <= ldmc_pkg::LDMC_DP_DOWN;
                        end else if (dp_init_done[i]) begin
                            data_path_state_machine[i] <= ldmc_pkg::LDMC_DP_ACT;
                        end
                    end
                    ldmc_pkg::LDMC_DP_ACT: begin
                        if (!oper_s2 || data_path_teardown_request[i]) begin
                            data_path_state_machine[i] <= ldmc_pkg::LDMC_DP_DOWN;
                        end
                    end
                    ldmc_pkg::LDMC_DP_DOWN: begin
                        if (dp_deinit_done[i]) begin
                            data_path_state_machine[i] <= ldmc_pkg::LDMC_DP_OFF;
                        end
                    end
                    default: data_path_state_machine[i] <= ldmc_pkg::LDMC_DP_OFF;
                endcase
            end
        end
        assign dp_initializing[i] = data_path_state_machine[i] == ldmc_pkg::LDMC_DP_INIT;
        assign dp_active[i] = data_path_state_machine[i] == ldmc_pkg::LDMC_DP_ACT;
    end

    // combined muting control; each output has its own register below
    always_comb begin
        // host off, or the state machine keeps it off
        next_tx_disabled = tx_output_off_control | ~dp_active;
        // auto squelch dropped for the non-pluggable-host category
        tx_auto_sq = {L{TX_AUTO_SQ_SUPPORTED && !host_cat_s2}} & ~tx_auto_squelch_off &
            ~tx_valid_s2;
        // disable wins: squelch masked while disabled
        next_tx_squelched = ~next_tx_disabled & (tx_force_squelch | tx_auto_sq);
        next_rx_disabled = rx_output_off_control;
        // only the internal controller squelches rx
        rx_ready = rx_valid_s2 & rx_resources_ready & dp_active;
        next_rx_squelched = {L{RX_AUTO_SQ_SUPPORTED}} & ~rx_auto_squelch_off & ~rx_ready;
    end

    // outputs start muted: disabled tx, squelched rx
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_output_disabled <= 8'hFF;
        end else begin
            tx_output_disabled <= next_tx_disabled;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_output_squelched <= 8'h00;
        end else begin
            tx_output_squelched <= next_tx_squelched;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_output_disabled <= 8'h00;
        end else begin
            rx_output_disabled <= next_rx_disabled;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_output_squelched <= 8'hFF;
        end else begin
            rx_output_squelched <= next_rx_squelched;
        end
    end

    a_tx_disable_init: assert property (@(posedge hclk) disable iff (!hresetn)
        dp_initializing != 8'h00 |=> (tx_output_disabled & $past(dp_initializing)) ==
        $past(dp_initializing)) else $error("tx enabled during init");
    a_tx_disable_masks: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_output_disabled & tx_output_squelched) == 8'h00)
        else $error("squelch not masked by disable");
    a_tx_host_off: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 (tx_output_disabled & $past(tx_output_off_control)) == $past(tx_output_off_control))
        else $error("host tx disable ignored");
    a_tx_force_sq: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 $past(tx_force_squelch & ~tx_output_off_control & dp_active) ==
        ($past(tx_force_squelch & ~tx_output_off_control & dp_active) & tx_output_squelched))
        else $error("forced tx squelch missing");
    a_rx_disable_host: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 rx_output_disabled == $past(rx_output_off_control))
        else $error("rx disable not host");
    a_rx_sq_auto_off: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 ($past(rx_auto_squelch_off) & rx_output_squelched) == 8'h00)
        else $error("rx squelch with controller off");
    a_rx_sq_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 ($past(~rx_ready & ~rx_auto_squelch_off) & ~rx_output_squelched) == 8'h00)
        else $error("rx unsquelched early");
    a_dp_no_init_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        !oper_s2 && dp_initializing == 8'h00 |=> dp_initializing == 8'h00)
        else $error("init started outside operational");
    a_dp_auto_init: assert property (@(posedge hclk) disable iff (!hresetn)
        oper_s2 && data_path_state_machine[0] == ldmc_pkg::LDMC_DP_OFF &&
        !data_path_teardown_request[0] |=> dp_initializing[0])
        else $error("lane 0 did not start init");

    a_dp_low_pwr: assert property (@(posedge hclk) disable iff (!hresetn)
        low_pwr_s2 && dp_initializing == 8'h00 |=> dp_initializing == 8'h00)
        else $error("init started in low power");

    a_teardown_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_hit && ap_addr == ldmc_pkg::ADR_TEARDOWN |=>
        data_path_teardown_request == $past(hwdata[7:0]))
        else $error("teardown write lost");

    a_tx_auto_host_cat: assert property (@(posedge hclk) disable iff (!hresetn)
        host_cat_s2 && tx_force_squelch == 8'h00 |=> tx_output_squelched == 8'h00)
        else $error("tx auto squelch in host category");

    a_tx_sq_auto_off: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 ($past(tx_auto_squelch_off & ~tx_force_squelch) & tx_output_squelched) == 8'h00)
        else $error("tx squelch with controller off");

    a_bank_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_hit && ap_addr == ldmc_pkg::ADR_BANK |=> lane_bank == $past(hwdata[1:0]))
        else $error("bank write lost");

    a_advert_layout: assert property (@(posedge hclk) disable iff (!hresetn)
        ap_valid && !ap_write && ap_addr == ldmc_pkg::ADR_ADVERT |->
        hrdata[ldmc_pkg::BIT_LAYOUT_PAGE])
        else $error("layout page not advertised");

    c_init_done: cover property (@(posedge hclk) disable iff (!hresetn)
        dp_initializing[0] ##1 dp_active[0]);
    c_teardown: cover property (@(posedge hclk) disable iff (!hresetn)
        dp_active[1] ##1 !dp_active[1]);
    c_rx_unsq: cover property (@(posedge hclk) disable iff (!hresetn)
        rx_output_squelched[0] ##1 !rx_output_squelched[0]);
    c_tx_force: cover property (@(posedge hclk) disable iff (!hresetn)
        tx_output_squelched[2]);
    c_rx_disable: cover property (@(posedge hclk) disable iff (!hresetn)
        rx_output_disabled[7]);
endmodule // ldmc_top

// >>> dv/ldmc_lane_engine.sv
// lane data path engine model: answers init and teardown requests per lane
// assumes the bench holds a lane's go level high while that lane should progress
`timescale 1ns/100ps
module ldmc_lane_engine #(
    parameter int DELAY = 3
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] init_go,
    input wire logic [7:0] deinit_go,
    output logic [7:0] dp_init_done,
    output logic [7:0] dp_deinit_done
);
    int cnt [8];
    // lane i raises done DELAY+i+1 cycles after its go level rises, so lanes finish apart
    // done is a one-cycle pulse; a held go level never repeats it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_init_done <= 8'h00;
            dp_deinit_done <= 8'h00;
            foreach (cnt[i]) cnt[i] <= 0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (!(init_go[i] || deinit_go[i])) cnt[i] <= 0;
                else if (cnt[i] <= DELAY + i) cnt[i] <= cnt[i] + 1;
                dp_init_done[i] <= init_go[i] && (cnt[i] == DELAY + i);
                dp_deinit_done[i] <= deinit_go[i] && (cnt[i] == DELAY + i);
            end
        end
    end
endmodule // ldmc_lane_engine

// >>> dv/test_lane_datapath_mute_control.sv
// self-checking bench for the lane data path mute control block
// assumes the ahb-lite slave answers with hreadyout and a lane engine model
`timescale 1ns/100ps
module test_lane_datapath_mute_control;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, lane_bank;
    logic [2:0] hsize;
    logic module_operational_state, module_low_power_state, non_pluggable_host_category;
    logic [7:0] dp_init_done, dp_deinit_done, tx_input_valid, rx_input_valid;
    logic [7:0] rx_resources_ready, init_go, deinit_go;
    logic [7:0] tx_output_disabled, tx_output_squelched, rx_output_disabled;
    logic [7:0] rx_output_squelched;
    int error_cnt, n_checks, cycles;
    assign hready = hreadyout;
    ldmc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .module_operational_state,
        .module_low_power_state, .non_pluggable_host_category, .dp_init_done,
        .dp_deinit_done, .tx_input_valid, .rx_input_valid, .rx_resources_ready,
        .tx_output_disabled, .tx_output_squelched, .rx_output_disabled,
        .rx_output_squelched, .lane_bank);
    ldmc_lane_engine eng (.hclk, .hresetn, .init_go, .deinit_go, .dp_init_done,
        .dp_deinit_done);
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // a hung handshake lands here rather than spinning forever
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic chk8(string name, logic [7:0] seen, logic [7:0] exp);
        check(name, {24'h0, seen}, {24'h0, exp});
    endtask
    // single word transfer: address phase held until hready, then data phase
    task automatic bus(logic wr, logic [11:0] adr, logic [31:0] wd);
        htrans <= 2'h2;
        haddr <= {20'h0, adr};
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic rd_chk(string name, logic [11:0] adr, logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        check(name, rd, exp);
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic t_reset_values();
        chk8("tx_dis", tx_output_disabled, 8'hFF);
        chk8("tx_sq", tx_output_squelched, 8'h00);
        chk8("rx_dis", rx_output_disabled, 8'h00);
        chk8("rx_sq", rx_output_squelched, 8'hFF);
        rd_chk("teardown", ldmc_pkg::ADR_TEARDOWN, 32'h0);
        rd_chk("advert", ldmc_pkg::ADR_ADVERT, 32'h80);
        rd_chk("unmapped", 12'h0F0, 32'h0);
    endtask
    task automatic t_bank();
        bus(1'b1, ldmc_pkg::ADR_BANK, 32'h7);
        settle(3);
        chk8("bank", {6'h0, lane_bank}, 8'h03);
        rd_chk("bank_rd", ldmc_pkg::ADR_BANK, 32'h3);
    endtask
    task automatic t_init();
        settle(8);
        rd_chk("idle_off", ldmc_pkg::ADR_STATUS, 32'h0);
        bus(1'b1, ldmc_pkg::ADR_TEARDOWN, 32'hFF); // host suppresses auto start
        module_operational_state <= 1'b1;
        module_low_power_state <= 1'b0;
        settle(8);
        rd_chk("held_off", ldmc_pkg::ADR_STATUS, 32'h0);
        // lanes 4-7 clear their teardown bits and initialize; lanes 0-3 stay held off
        bus(1'b1, ldmc_pkg::ADR_TEARDOWN, 32'h0F);
        settle(4);
        rd_chk("initing", ldmc_pkg::ADR_STATUS, 32'hF0);
        chk8("tx_hold", tx_output_disabled, 8'hFF);
        init_go <= 8'hF0;
        settle(16);
        rd_chk("active", ldmc_pkg::ADR_STATUS, 32'hF000);
        chk8("tx_on", tx_output_disabled, 8'h0F);
    endtask
    task automatic t_tx_mute();
        chk8("tx_auto", tx_output_squelched[7:4], 8'h0F);
        tx_input_valid <= 8'hFF;
        settle(6);
        chk8("tx_valid", tx_output_squelched[7:4], 8'h00);
        bus(1'b1, ldmc_pkg::ADR_TX_FORCE_SQ, 32'hFF);
        settle(3);
        chk8("tx_force", tx_output_squelched[7:4], 8'h0F);
        bus(1'b1, ldmc_pkg::ADR_TX_OFF, 32'h30);
        settle(3);
        chk8("tx_off", tx_output_disabled, 8'h3F);
        chk8("tx_mask", tx_output_squelched[7:4], 8'h0C);
        bus(1'b1, ldmc_pkg::ADR_TX_OFF, 32'h0);
        bus(1'b1, ldmc_pkg::ADR_TX_FORCE_SQ, 32'h0);
        tx_input_valid <= 8'h00;
        non_pluggable_host_category <= 1'b1;
        settle(6);
        chk8("tx_np", tx_output_squelched[7:4], 8'h00);
        non_pluggable_host_category <= 1'b0;
        bus(1'b1, ldmc_pkg::ADR_TX_AUTO_SQ_OFF, 32'hC0);
        settle(3);
        chk8("tx_autooff", tx_output_squelched[7:4], 8'h03);
    endtask
    task automatic t_rx_mute();
        chk8("rx_noin", rx_output_squelched[7:4], 8'h0F);
        rx_input_valid <= 8'hFF;
        settle(6);
        chk8("rx_nores", rx_output_squelched[7:4], 8'h0F);
        rx_resources_ready <= 8'hFF;
        settle(6);
        chk8("rx_open", rx_output_squelched[7:4], 8'h00);
        bus(1'b1, ldmc_pkg::ADR_RX_OFF, 32'h81);
        settle(3);
        chk8("rx_off", rx_output_disabled, 8'h81);
        rx_input_valid <= 8'h00;
        bus(1'b1, ldmc_pkg::ADR_RX_AUTO_SQ_OFF, 32'h30);
        settle(6);
        chk8("rx_autooff", rx_output_squelched[7:4], 8'h0C);
    endtask
    task automatic t_teardown();
        bus(1'b1, ldmc_pkg::ADR_TEARDOWN, 32'hFF);
        // drop the init go level so the engine counter restarts for teardown
        init_go <= 8'h00;
        settle(4);
        rd_chk("going_down", ldmc_pkg::ADR_STATUS, 32'h0);
        deinit_go <= 8'hF0;
        settle(16);
        deinit_go <= 8'h00;
        settle(8);
        // a held set bit must not restart anything
        rd_chk("stays_off", ldmc_pkg::ADR_STATUS, 32'h0);
        bus(1'b1, ldmc_pkg::ADR_TEARDOWN, 32'h00);
        settle(4);
        rd_chk("reinit", ldmc_pkg::ADR_STATUS, 32'hFF);
    endtask
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
        {module_operational_state, non_pluggable_host_category} = 2'b00;
        module_low_power_state = 1'b1;
        {tx_input_valid, rx_input_valid, rx_resources_ready} = '0;
        {init_go, deinit_go} = 16'h0;
        settle(3);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        hsize <= 3'h2;
        @(posedge hclk);
        t_reset_values();
        t_bank();
        t_init();
        t_tx_mute();
        t_rx_mute();
        t_teardown();
        print_verdict();
    end
endmodule // test_lane_datapath_mute_control
